// file: rtl/adc_port_pkg.sv
// Functional notes
// R01: Null byte clears port flag, no transfer
// R02: Data output floats while select high
// R03: Clock edges ignored unless select low
// R04: Write command then 32 bits loads register
// R05: Read command then 32 bits shifted out
// R06: After 32 bits return to command mode
// R07: Offset, gain, setup read-write; data read-only
// R08: Byte 0x02 writes the gain register
// R09: Power save halts filter, clear resumes
// R10: Standby keeps oscillator running
// R11: Sleep stops oscillator, 20 ms wake
// R12: Soft reset bit initialises internal state
// R13: Reset-done set, cleared by setup read
// R14: Reset loads zero, zero, unity gain
// R15: Host clears reset bit, command mode follows
// R16: Reset write sets only the reset bit
// R17: Input ground bit shorts signal inputs
// R18: Latch outputs follow setup bits 24:23
// R19: Rate scale bit scales rates by 5/6
// R20: Rate code selects output word rate
// R21: Polarity bit picks unipolar or bipolar
// R22: Open lead bit enables test current
// R23: Fixed setup bit positions, unused read zero
// R24: Rate code table, other codes unused
// R25: Byte 0xFE ends resync, command mode
package adc_port_pkg;
    localparam int          WORD_W        = 32;
    localparam int          RATE_W        = 14;
    localparam int          WAKE_MS       = 20;
    localparam int          CLOCK_HZ      = 40_000_000;
    localparam int          WAKE_CYCLES   = WAKE_MS * (CLOCK_HZ / 1000);
    localparam int          CNT_W         = 20;
    // Setup register bit positions
    localparam int          SAVE_DEPTH    = 31;
    localparam int          POWER_SAVE    = 30;
    localparam int          SOFT_RESET    = 29;
    localparam int          RESET_DONE    = 28;
    localparam int          INPUT_GROUND  = 27;
    localparam int          REF_RANGE     = 25;
    localparam int          LATCH_HI      = 24;
    localparam int          LATCH_LO      = 23;
    localparam int          RATE_SCALE    = 19;
    localparam int          RATE_HI       = 14;
    localparam int          RATE_LO       = 11;
    localparam int          POLARITY      = 10;
    localparam int          OPEN_LEAD     = 9;
    localparam logic [31:0] SETUP_WMASK   = 32'hEB887E00;
    localparam logic [31:0] SETUP_RESET   = 32'h00000000;
    localparam logic [31:0] OFFSET_RESET  = 32'h00000000;
    localparam logic [31:0] GAIN_RESET    = 32'h01000000;
    // Command bytes
    localparam logic [7:0]  BYTE_NULL     = 8'h00;
    localparam logic [7:0]  BYTE_RESYNC   = 8'hFF;
    localparam logic [7:0]  BYTE_SYNC_END = 8'hFE;
    localparam logic [7:0]  CMD_WR_OFFSET = 8'h01;
    localparam logic [7:0]  CMD_WR_GAIN   = 8'h02;
    localparam logic [7:0]  CMD_WR_SETUP  = 8'h03;
    localparam logic [7:0]  CMD_RD_OFFSET = 8'h09;
    localparam logic [7:0]  CMD_RD_GAIN   = 8'h0A;
    localparam logic [7:0]  CMD_RD_SETUP  = 8'h0B;
    localparam logic [7:0]  CMD_RD_DATA   = 8'h0C;
    localparam logic [2:0]  BYTE_LAST     = 3'h7;
    localparam logic [4:0]  WORD_LAST     = 5'h1F;

    typedef enum logic [1:0] {
        MODE_CMD   = 2'b00,
        MODE_WRITE = 2'b01,
        MODE_READ  = 2'b10
    } port_mode_t;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_OFFSET = 3'b001,
        SEL_GAIN   = 3'b010,
        SEL_SETUP  = 3'b011,
        SEL_DATA   = 3'b100
    } reg_sel_t;

    typedef enum logic [1:0] {
        PWR_NORMAL  = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SLEEP   = 2'b10,
        PWR_WAKE    = 2'b11
    } power_state_t;
endpackage : adc_port_pkg

// file: rtl/adc_serial_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_port #(
    parameter int WAKE_COUNT = adc_port_pkg::WAKE_CYCLES
) (
    // System
    input  wire  logic                              clock,
    input  wire  logic                              reset,
    // Serial port pins
    input  wire  logic                              sclk,
    input  wire  logic                              cs_n,
    input  wire  logic                              sdi,
    output logic                                    sdo_out,
    output logic                                    sdo_oe,
    // Converter side
    input  wire  logic [adc_port_pkg::WORD_W-1:0]   conv_word,
    input  wire  logic                              conv_strobe,
    input  wire  logic                              ext_clock_pin,
    // Setup outputs
    output logic                                    input_ground,
    output logic                                    ref_range,
    output logic [1:0]                              latch_outputs,
    output logic                                    polarity_sel,
    output logic                                    open_lead_source_en,
    output logic [adc_port_pkg::RATE_W-1:0]         word_rate_quarter,
    output logic                                    word_rate_valid,
    output logic                                    filter_run,
    output logic                                    osc_run,
    output logic                                    reset_done_flag,
    output logic                                    port_flag
);
    import adc_port_pkg::*;

    // ************************************************************
    // Link domain: shifting on the serial clock
    // ************************************************************
    port_mode_t        mode_q;
    logic [4:0]        bit_cnt_q;
    logic [31:0]       rx_q;
    logic [31:0]       tx_q;
    reg_sel_t          sel_q;
    logic              wr_tgl_q;
    logic              rd_tgl_q;
    logic [31:0]       wr_word_q;
    reg_sel_t          wr_sel_q;
    logic              link_clear_q;

    logic [31:0]       offset_q;
    logic [31:0]       gain_q;
    logic [31:0]       setup_q;
    logic [31:0]       data_q;
    logic              reset_done_q;

    function automatic reg_sel_t cmd_target(input logic [7:0] b);
        case (b)
            CMD_WR_OFFSET, CMD_RD_OFFSET: cmd_target = SEL_OFFSET;
            CMD_WR_GAIN, CMD_RD_GAIN:     cmd_target = SEL_GAIN;
            CMD_WR_SETUP, CMD_RD_SETUP:   cmd_target = SEL_SETUP;
            CMD_RD_DATA:                  cmd_target = SEL_DATA;
            default:                      cmd_target = SEL_NONE;
        endcase
    endfunction : cmd_target

    wire logic [31:0]  rx_next   = {rx_q[30:0], sdi};
    wire logic [7:0]   byte_val  = rx_next[7:0];
    wire logic         byte_done = (mode_q == MODE_CMD) && (bit_cnt_q[2:0] == BYTE_LAST);
    wire logic         word_done = (mode_q != MODE_CMD) && (bit_cnt_q == WORD_LAST);
    wire reg_sel_t     byte_sel  = cmd_target(byte_val);
    wire logic         byte_rd   = byte_val[3];
    wire logic         start_wr  = byte_done && (byte_sel != SEL_NONE) && (byte_sel != SEL_DATA) && !byte_rd;
    wire logic         start_rd  = byte_done && (byte_sel != SEL_NONE) && byte_rd;
    wire logic [31:0]  setup_view = setup_q | ({31'h0, reset_done_q} << RESET_DONE);
    wire logic [31:0]  rd_word   = (byte_sel == SEL_OFFSET) ? offset_q :
                                   (byte_sel == SEL_GAIN)   ? gain_q :
                                   (byte_sel == SEL_SETUP)  ? setup_view : data_q;
    wire logic         read_busy = (mode_q == MODE_READ);

    // Framing state, cleared while select is high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            mode_q    <= MODE_CMD;
            bit_cnt_q <= 5'h00;
            rx_q      <= 32'h00000000;
            tx_q      <= 32'h00000000;
            sel_q     <= SEL_NONE;
        end else begin
            rx_q      <= rx_next;
            bit_cnt_q <= (byte_done || word_done) ? 5'h00 : bit_cnt_q + 5'h01;
            tx_q      <= {tx_q[30:0], 1'b0};
            if (start_wr) begin                                      // R04
                mode_q <= MODE_WRITE;
                sel_q  <= byte_sel;
            end else if (start_rd) begin                             // R05
                mode_q <= MODE_READ;
                sel_q  <= byte_sel;
                tx_q   <= rd_word;
            end else if (word_done) begin                            // R06
                mode_q <= MODE_CMD;
            end
        end
    end

    // Events toward the core, kept across frames
    always_ff @(posedge sclk or posedge link_clear_q) begin
        if (link_clear_q) begin
            wr_tgl_q  <= 1'b0;
            rd_tgl_q  <= 1'b0;
            wr_word_q <= 32'h00000000;
            wr_sel_q  <= SEL_NONE;
            port_flag <= 1'b0;
        end else if (!cs_n) begin                                    // R03
            if (word_done && mode_q == MODE_WRITE) begin
                wr_word_q <= rx_next;
                wr_sel_q  <= sel_q;
                wr_tgl_q  <= ~wr_tgl_q;
            end
            if (start_rd && byte_sel == SEL_SETUP) begin
                rd_tgl_q <= ~rd_tgl_q;
            end
            if (byte_done && byte_val == BYTE_RESYNC) begin
                port_flag <= 1'b1;
            end else if (byte_done && (byte_val == BYTE_NULL || byte_val == BYTE_SYNC_END)) begin
                port_flag <= 1'b0;                                   // R01 R25
            end
        end
    end

    // Output driver changes on the falling edge
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sdo_out <= 1'b0;                                         // R02
            sdo_oe  <= 1'b0;
        end else begin
            sdo_out <= (mode_q == MODE_READ) ? tx_q[31] : 1'b0;
            sdo_oe  <= 1'b1;
        end
    end

    // ************************************************************
    // Core domain: crossing of link events
    // ************************************************************
    logic              wr_meta_q;
    logic              wr_sync_q;
    logic              wr_seen_q;
    logic              rd_meta_q;
    logic              rd_sync_q;
    logic              rd_seen_q;
    logic              ext_meta_q;
    logic              ext_sync_q;
    logic              busy_meta_q;
    logic              busy_sync_q;

    always_ff @(posedge clock) begin
        link_clear_q <= reset;
        wr_meta_q    <= wr_tgl_q;
        wr_sync_q    <= wr_meta_q;
        rd_meta_q    <= rd_tgl_q;
        rd_sync_q    <= rd_meta_q;
        ext_meta_q   <= ext_clock_pin;
        ext_sync_q   <= ext_meta_q;
        busy_meta_q  <= read_busy;
        busy_sync_q  <= busy_meta_q;
        if (reset) begin
            wr_seen_q <= 1'b0;
            rd_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_sync_q;
            rd_seen_q <= rd_sync_q;
        end
    end

    wire logic         wr_event   = wr_sync_q ^ wr_seen_q;
    wire logic         rd_event   = rd_sync_q ^ rd_seen_q;
    wire logic         setup_wr   = wr_event && (wr_sel_q == SEL_SETUP);
    wire logic         soft_reset = setup_wr && wr_word_q[SOFT_RESET];

    // ************************************************************
    // Core domain: registers
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset || soft_reset) begin                               // R12 R14
            offset_q <= OFFSET_RESET;
            gain_q   <= GAIN_RESET;
            setup_q  <= reset ? SETUP_RESET : (SETUP_RESET | (32'h1 << SOFT_RESET)); // R16
        end else if (wr_event) begin                                 // R07
            if (wr_sel_q == SEL_OFFSET) begin
                offset_q <= wr_word_q;
            end
            if (wr_sel_q == SEL_GAIN) begin                          // R08
                gain_q <= wr_word_q;
            end
            if (setup_wr) begin                                      // R15 R23
                setup_q <= wr_word_q & SETUP_WMASK;
            end
        end
    end

    // Reset-done flag: a completing reset wins over a read clear
    always_ff @(posedge clock) begin
        if (reset) begin
            reset_done_q <= 1'b0;
        end else if (soft_reset) begin                               // R13
            reset_done_q <= 1'b1;
        end else if (rd_event) begin
            reset_done_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            data_q <= 32'h00000000;
        end else if (conv_strobe && !busy_sync_q) begin
            data_q <= conv_word;
        end
    end

    // ************************************************************
    // Core domain: word rate decode
    // ************************************************************
    function automatic logic [RATE_W:0] base_rate(input logic [3:0] code);
        case (code)
            4'h0:    base_rate = 15'h01E0;
            4'h1:    base_rate = 15'h00F0;
            4'h2:    base_rate = 15'h0078;
            4'h3:    base_rate = 15'h003C;
            4'h4:    base_rate = 15'h001E;
            4'h8:    base_rate = 15'h3C00;
            4'h9:    base_rate = 15'h1E00;
            4'hA:    base_rate = 15'h0F00;
            4'hB:    base_rate = 15'h0780;
            4'hC:    base_rate = 15'h03C0;
            default: base_rate = 15'h0000;
        endcase
    endfunction : base_rate

    wire logic [RATE_W:0]   rate_base   = base_rate(setup_q[RATE_HI:RATE_LO]);           // R20 R24
    wire logic [RATE_W+3:0] rate_times5 = {3'h0, rate_base} * 18'h00005;
    wire logic [RATE_W+3:0] rate_scaled = rate_times5 / 18'h00006;
    wire logic [RATE_W-1:0] rate_next   = setup_q[RATE_SCALE] ? rate_scaled[RATE_W-1:0] // R19
                                                              : rate_base[RATE_W-1:0];

    always_ff @(posedge clock) begin
        if (reset) begin
            word_rate_quarter <= '0;
            word_rate_valid   <= 1'b0;
        end else begin
            word_rate_quarter <= rate_next;
            word_rate_valid   <= (rate_base != '0);
        end
    end

    // ************************************************************
    // Core domain: power modes
    // ************************************************************
    power_state_t      pwr_q;
    power_state_t      pwr_d;
    logic [CNT_W-1:0]  wake_cnt_q;

    wire logic         save_on  = setup_q[POWER_SAVE];
    wire logic         deep_sel = setup_q[SAVE_DEPTH];
    wire logic         wake_end = (wake_cnt_q == CNT_W'(WAKE_COUNT - 1));

    always_comb begin
        case (pwr_q)
            PWR_NORMAL:  pwr_d = !save_on ? PWR_NORMAL : (deep_sel ? PWR_SLEEP : PWR_STANDBY); // R09 R10
            PWR_STANDBY: pwr_d = save_on ? PWR_STANDBY : PWR_NORMAL;
            PWR_SLEEP:   pwr_d = save_on ? PWR_SLEEP : (ext_sync_q ? PWR_NORMAL : PWR_WAKE);  // R11
            PWR_WAKE:    pwr_d = save_on ? (deep_sel ? PWR_SLEEP : PWR_STANDBY)
                                         : (wake_end ? PWR_NORMAL : PWR_WAKE);
            default:     pwr_d = PWR_NORMAL;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pwr_q      <= PWR_NORMAL;
            wake_cnt_q <= '0;
            filter_run <= 1'b1;
            osc_run    <= 1'b1;
        end else begin
            pwr_q      <= pwr_d;
            wake_cnt_q <= (pwr_q == PWR_WAKE) ? wake_cnt_q + 1'b1 : '0;
            filter_run <= (pwr_d == PWR_NORMAL);
            osc_run    <= (pwr_d != PWR_SLEEP);
        end
    end

    // ************************************************************
    // Setup outputs
    // ************************************************************
    assign input_ground        = setup_q[INPUT_GROUND];              // R17
    assign ref_range           = setup_q[REF_RANGE];
    assign latch_outputs       = setup_q[LATCH_HI:LATCH_LO];         // R18
    assign polarity_sel        = setup_q[POLARITY];                  // R21
    assign open_lead_source_en = setup_q[OPEN_LEAD];                 // R22
    assign reset_done_flag     = reset_done_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence leave_sleep_s;
        pwr_q == PWR_SLEEP && !save_on && !ext_sync_q;
    endsequence

    sequence wake_hold_s;
        pwr_q == PWR_WAKE && !filter_run;
    endsequence

    chk_sdo_float: assert property (@(posedge clock) cs_n |-> !sdo_oe) // R02
        else $error("data output driven while select high");

    chk_gain_cmd: assert property (@(posedge sclk) disable iff (cs_n) // R08
        byte_done && byte_val == CMD_WR_GAIN |=> mode_q == MODE_WRITE && sel_q == SEL_GAIN)
        else $error("gain write command not decoded");

    chk_word_end: assert property (@(posedge sclk) disable iff (cs_n) // R06
        word_done |=> mode_q == MODE_CMD && bit_cnt_q == 5'h00)
        else $error("port did not return to command mode");

    chk_null_byte: assert property (@(posedge sclk) disable iff (cs_n) // R01
        byte_done && byte_val == BYTE_NULL |=> !port_flag && mode_q == MODE_CMD)
        else $error("null byte mishandled");

    chk_resync_end: assert property (@(posedge sclk) disable iff (cs_n) // R25
        byte_done && byte_val == BYTE_SYNC_END |=> !port_flag && mode_q == MODE_CMD)
        else $error("resync end byte mishandled");

    chk_soft_reset: assert property (@(posedge clock) disable iff (reset) // R12
        soft_reset |=> setup_q == (32'h1 << SOFT_RESET) && gain_q == GAIN_RESET
                       && offset_q == OFFSET_RESET && reset_done_q)
        else $error("soft reset state wrong");

    chk_done_clear: assert property (@(posedge clock) disable iff (reset) // R13
        rd_event && !soft_reset |=> !reset_done_flag)
        else $error("reset-done flag not cleared by read");

    chk_latch_follow: assert property (@(posedge clock) disable iff (reset) // R18
        setup_wr && !wr_word_q[SOFT_RESET] |=> latch_outputs == $past(wr_word_q[LATCH_HI:LATCH_LO]))
        else $error("latch outputs do not follow setup write");

    chk_sleep_wake: assert property (@(posedge clock) disable iff (reset) // R11
        leave_sleep_s |=> wake_hold_s ##1 (pwr_q == PWR_WAKE) && osc_run)
        else $error("sleep exit skipped oscillator start-up");

    chk_wake_bound: assert property (@(posedge clock) disable iff (reset) // R11
        pwr_q == PWR_WAKE |-> wake_cnt_q < CNT_W'(WAKE_COUNT))
        else $error("wake delay overran");

    chk_standby_osc: assert property (@(posedge clock) disable iff (reset) // R10
        pwr_q == PWR_NORMAL && save_on && !deep_sel |=> !filter_run && osc_run)
        else $error("standby stopped oscillator");

    chk_rate_scale: assert property (@(posedge clock) disable iff (reset) // R19
        setup_q[RATE_HI:RATE_LO] == 4'h0 && setup_q[RATE_SCALE] ##1 $stable(setup_q)
        |-> word_rate_quarter == 14'h0190)
        else $error("scaled rate wrong");

    chk_read_load: assert property (@(posedge sclk) disable iff (cs_n) // R05
        start_rd |=> mode_q == MODE_READ && tx_q == $past(rd_word))
        else $error("read word not loaded");

    chk_write_start: assert property (@(posedge sclk) disable iff (cs_n) // R04
        start_wr |=> mode_q == MODE_WRITE && sel_q == $past(byte_sel))
        else $error("write command not decoded");

    chk_offset_land: assert property (@(posedge clock) disable iff (reset) // R07
        wr_event && wr_sel_q == SEL_OFFSET |=> offset_q == $past(wr_word_q))
        else $error("offset write lost");

    chk_rate_unused: assert property (@(posedge clock) disable iff (reset) // R24
        !(setup_q[RATE_HI:RATE_LO] inside {[4'h0:4'h4], [4'h8:4'hC]}) ##1 $stable(setup_q)
        |-> !word_rate_valid && word_rate_quarter == 14'h0000)
        else $error("unused rate code reported valid");
endmodule : adc_serial_config_port
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Serial port pins
    output var logic sclk,
    output var logic cs_n,
    output var logic sdi,
    input  wire logic sdo
);
    // A clean rising select edge at start clears the port framing
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi  = 1'b0;
        #1 cs_n = 1'b1;
    end

    // Select changes only while the clock stands still
    task automatic sel(input logic v);
        #24 cs_n = v;
        #24;
    endtask : sel

    // MSB first, data set after the falling edge, sampled before the rising edge
    task automatic shift(input logic [39:0] bits, input int n, output logic [31:0] rd);
        int i;
        rd = 32'h0;
        for (i = 0; i < n; i++) begin
            sdi = bits[39-i];
            #24;
            if (i >= 8) rd[39-i] = sdo;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        sdi = ~sdi;
    endtask : shift
endmodule : host_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adc_port_pkg::*;
    localparam int WAKE = 16;
    logic        clock = 1'b0, reset = 1'b1, conv_strobe, ext_clock_pin, sdo_last = 1'b0;
    logic [31:0] conv_word;
    wire         sclk, cs_n, sdi, sdo_out, sdo_oe, sdo_line, input_ground, ref_range, polarity_sel;
    wire         open_lead_source_en, word_rate_valid, filter_run, osc_run, reset_done_flag, port_flag;
    wire [1:0]   latch_outputs;
    wire [13:0]  word_rate_quarter;
    int          n_errors = 0, checked = 0, seed = 71143, i, q;
    logic [31:0] m_setup = 32'h0, m_offset = 32'h0, m_gain = GAIN_RESET, m_data, rd, wd;
    logic        m_done = 1'b0;

    always #12.5 clock = ~clock;
    always @(posedge sclk) if (sdo_oe) sdo_last <= sdo_out;
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;

    adc_serial_config_port #(.WAKE_COUNT(WAKE)) u_dut (.clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_word(conv_word), .conv_strobe(conv_strobe),
        .ext_clock_pin(ext_clock_pin), .input_ground(input_ground), .ref_range(ref_range),
        .latch_outputs(latch_outputs), .polarity_sel(polarity_sel), .open_lead_source_en(open_lead_source_en),
        .word_rate_quarter(word_rate_quarter), .word_rate_valid(word_rate_valid), .filter_run(filter_run),
        .osc_run(osc_run), .reset_done_flag(reset_done_flag), .port_flag(port_flag));
    host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic txn(input logic [7:0] cmd, input logic [31:0] w);
        int n;
        n = (cmd inside {8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h0B, 8'h0C}) ? 40 : 8;
        u_host.sel(1'b0);
        u_host.shift({cmd, w}, n, rd);
        u_host.sel(1'b1);
        repeat (6) @(posedge clock);
    endtask : txn

    task automatic rdc(input logic [7:0] cmd, input logic [31:0] exp);
        txn(cmd, 32'h0);
        check(rd, exp);
    endtask : rdc

    task automatic rsetup;
        rdc(CMD_RD_SETUP, m_setup | {3'h0, m_done, 28'h0});
        m_done = 1'b0;
    endtask : rsetup

    task automatic wsetup(input logic [31:0] w);
        txn(CMD_WR_SETUP, w);
        if (w[29]) begin
            {m_setup, m_offset, m_gain, m_done} = {32'h20000000, 32'h0, GAIN_RESET, 1'b1};
        end else m_setup = w & SETUP_WMASK;
    endtask : wsetup

    task automatic chk_pwr(input logic [1:0] e);
        check({filter_run, osc_run}, e);
    endtask : chk_pwr

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        #1_000_000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (3) begin
            @(posedge clock);
            conv_word     <= $random(seed);
            conv_strobe   <= 1'($random(seed));
            ext_clock_pin <= 1'($random(seed));
        end
        @(posedge clock);
        reset         <= 1'b0;
        conv_strobe   <= 1'b0;
        ext_clock_pin <= 1'b0;
        repeat (3) @(posedge clock);
        rsetup();
        rdc(CMD_RD_OFFSET, m_offset);
        rdc(CMD_RD_GAIN, m_gain);
        check({filter_run, osc_run, reset_done_flag, word_rate_valid, word_rate_quarter}, 18'h341E0);
        for (i = 0; i < 4; i++) begin
            wd = $random(seed);
            txn(CMD_WR_OFFSET, wd);
            m_offset = wd;
            m_gain = $random(seed);
            u_host.sel(1'b0);
            u_host.shift({BYTE_NULL, 32'h0}, 8, rd);
            u_host.shift({CMD_WR_GAIN, m_gain}, 40, rd);
            u_host.sel(1'b1);
            check(port_flag, 1'b0);
            u_host.sel(1'b0);
            u_host.shift({CMD_RD_OFFSET, 32'h0}, 40, rd);
            check(rd, m_offset);
            u_host.shift({CMD_RD_GAIN, 32'h0}, 40, rd);
            check(rd, m_gain);
            u_host.sel(1'b1);
        end
        @(posedge clock);
        conv_word <= $random(seed);
        conv_strobe <= 1'b1;
        @(posedge clock);
        conv_strobe <= 1'b0;
        m_data = conv_word;
        rdc(CMD_RD_DATA, m_data);
        for (i = 0; i < 32; i++) begin
            wd = ($random(seed) & 32'h0FF787FF) | (i[3:0] << 11) | (i[4] << 19);
            wsetup(wd);
            q = (wd[14:11] <= 4) ? 480 >> wd[14:11] : (wd[14:11] inside {[8:12]}) ? 15360 >> (wd[14:11] - 8) : 0;
            if (wd[19]) q = q * 5 / 6;
            check({input_ground, ref_range, latch_outputs, polarity_sel, open_lead_source_en, word_rate_valid,
                word_rate_quarter}, {wd[27], wd[25], wd[24:23], wd[10], wd[9], q != 0, q[13:0]});
            rsetup();
        end
        wd = $random(seed);
        u_host.sel(1'b0);
        u_host.shift({CMD_WR_OFFSET, wd}, 20, rd);
        u_host.sel(1'b1);
        check(sdo_oe, 1'b0);
        u_host.shift({CMD_WR_OFFSET, wd}, 40, rd);
        rdc(CMD_RD_OFFSET, m_offset);
        wsetup(32'h40000000);
        chk_pwr(2'b01);
        wsetup(32'h0);
        chk_pwr(2'b11);
        wsetup(32'hC0000000);
        chk_pwr(2'b00);
        wsetup(32'h0);
        chk_pwr(2'b01);
        repeat (WAKE + 8) @(posedge clock);
        chk_pwr(2'b11);
        ext_clock_pin <= 1'b1;
        wsetup(32'hC0000000);
        chk_pwr(2'b00);
        wsetup(32'h0);
        chk_pwr(2'b11);
        txn(CMD_WR_OFFSET, $random(seed));
        wsetup(32'h20000000);
        check(reset_done_flag, 1'b1);
        rsetup();
        check(reset_done_flag, 1'b0);
        rdc(CMD_RD_OFFSET, m_offset);
        rdc(CMD_RD_GAIN, m_gain);
        rsetup();
        wsetup(32'h0);
        rsetup();
        txn(BYTE_RESYNC, 32'h0);
        check(port_flag, 1'b1);
        txn(BYTE_SYNC_END, 32'h0);
        check(port_flag, 1'b0);
        txn(BYTE_RESYNC, 32'h0);
        txn(BYTE_NULL, 32'h0);
        check(port_flag, 1'b0);
        rdc(CMD_RD_GAIN, m_gain);
        conclude();
    end
endmodule : tb
`default_nettype wire
